// ==== core/dual_phase_dynamic_shift_register.sv ====
// Two-phase dynamic serial shift register: two 1024-position lanes or one
// 2048-position lane, each made of two interleaved halves.
// Assumes phase inputs are synchronous to core_clk and pulse-starts are at
// least two core cycles apart.
`timescale 1ns/1ps
module dual_phase_dynamic_shift_register #(
  parameter dsr_pkg::variant_t VARIANT = dsr_pkg::DUAL_RECIRC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic phase_1,
  input wire logic phase_2,
  input wire logic load_control,
  input wire logic [1:0] input_choice,
  input wire logic [1:0] data_in_first,
  input wire logic [1:0] data_in_second,
  output logic [1:0] data_out,
  output logic shift_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_data
);
  import dsr_pkg::*;

  localparam int LEN = (VARIANT == SINGLE_RECIRC) ? TOTAL_BITS : DUAL_LEN;
  localparam int AW = $clog2(LEN);
  localparam int PW = AW - 1;
  localparam int LANES = (VARIANT == SINGLE_RECIRC) ? 1 : NUM_LANES;

  dsr_store_if #(.AW(AW), .DW(NUM_LANES)) mem_bus ();

  dsr_store #(.DEPTH(LEN), .DW(NUM_LANES)) u_store (
    .core_clk(core_clk),
    .reset(reset),
    .port_s(mem_bus.store)
  );

  // ----------------------------------------------------------------------
  // Phase pulse detection
  // ----------------------------------------------------------------------
  logic ph1_prev_ff;
  logic ph2_prev_ff;
  logic ph1_start;
  logic ph2_start;
  logic take;
  shift_state_t state_ff;
  logic [1:0] buf_cnt_ff;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ph1_prev_ff <= 1'b0;
      ph2_prev_ff <= 1'b0;
    end else begin
      ph1_prev_ff <= phase_1;
      ph2_prev_ff <= phase_2;
    end
  end

  assign ph1_start = phase_1 & ~ph1_prev_ff;
  assign ph2_start = phase_2 & ~ph2_prev_ff;
  // A pulse start while the buffer is full or a move is in flight is refused.
  assign shift_ready = (state_ff == ST_IDLE) && (buf_cnt_ff < 2'(BUF_DEPTH));
  assign take = (ph1_start | ph2_start) & shift_ready;

  // ----------------------------------------------------------------------
  // Master stage: inputs caught at the pulse start
  // ----------------------------------------------------------------------
  logic half_ff;
  logic lc_ff;
  logic [1:0] sel_ff;
  logic [1:0] din1_ff;
  logic [1:0] din2_ff;
  logic [PW-1:0] ptr_ff [2];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      half_ff <= 1'b0;
      lc_ff <= 1'b0;
      sel_ff <= LANE_RESET;
      din1_ff <= LANE_RESET;
      din2_ff <= LANE_RESET;
    end else if (take) begin
      // Phase one wins if both starts coincide; that overlap is illegal anyway.
      half_ff <= ~ph1_start;
      lc_ff <= load_control;
      sel_ff <= input_choice;
      din1_ff <= data_in_first;
      din2_ff <= data_in_second;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            state_ff <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // The read is issued with the pulse start so the oldest bit of the half
  // arrives in ST_MOVE, where the slave write happens in the same slot.
  assign mem_bus.rd_en = take;
  assign mem_bus.rd_addr = {~ph1_start, ph1_start ? ptr_ff[0] : ptr_ff[1]};
  assign mem_bus.wr_en = (state_ff == ST_MOVE);
  assign mem_bus.wr_addr = {half_ff, ptr_ff[half_ff]};

  // ----------------------------------------------------------------------
  // Entered bit per lane
  // ----------------------------------------------------------------------
  logic [1:0] entered;

  for (genvar r = 0; r < NUM_LANES; r++) begin : g_lane
    if (r >= LANES) begin : g_unused
      assign entered[r] = 1'b0;
    end else if (VARIANT == DUAL_SELECT) begin : g_sel
      assign entered[r] = sel_ff[r] ? din2_ff[r] : din1_ff[r];
    end else begin : g_recirc
      assign entered[r] = lc_ff ? mem_bus.rd_data[r] : din1_ff[r];
    end
  end

  assign mem_bus.wr_data = entered;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ptr_ff[0] <= '0;
      ptr_ff[1] <= '0;
    end else if (state_ff == ST_MOVE) begin
      // Each half is a ring of LEN/2 slots; the pointer wraps by width.
      ptr_ff[half_ff] <= ptr_ff[half_ff] + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Last stage and output buffer
  // ----------------------------------------------------------------------
  logic [1:0] data_out_ff;
  logic [1:0] buf_mem_ff [BUF_DEPTH];
  logic buf_wp_ff;
  logic buf_rp_ff;
  logic push;
  logic pop;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_out_ff <= LANE_RESET;
    end else if (state_ff == ST_MOVE) begin
      data_out_ff <= mem_bus.rd_data;
    end
  end

  assign data_out = data_out_ff;
  assign push = (state_ff == ST_MOVE);
  assign pop = out_valid & out_ready;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      buf_mem_ff[0] <= LANE_RESET;
      buf_mem_ff[1] <= LANE_RESET;
      buf_wp_ff <= 1'b0;
    end else if (push) begin
      buf_mem_ff[buf_wp_ff] <= mem_bus.rd_data;
      buf_wp_ff <= ~buf_wp_ff;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      buf_rp_ff <= 1'b0;
      buf_cnt_ff <= COUNT_RESET;
    end else begin
      if (pop) begin
        buf_rp_ff <= ~buf_rp_ff;
      end
      buf_cnt_ff <= buf_cnt_ff + 2'(push) - 2'(pop);
    end
  end

  assign out_valid = (buf_cnt_ff != COUNT_RESET);
  assign out_data = buf_mem_ff[buf_rp_ff];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  recirc_keep_a: assert property (
    (state_ff == ST_MOVE && lc_ff && VARIANT != DUAL_SELECT)
      |-> mem_bus.wr_data[LANES-1:0] == mem_bus.rd_data[LANES-1:0])
    else $error("recirculated bit differs from output bit");

  load_take_a: assert property (
    (take && !load_control && VARIANT != DUAL_SELECT)
      ##1 1'b1 |-> mem_bus.wr_data[0] == $past(data_in_first[0]))
    else $error("loaded bit is not the data input");

  choice_low_a: assert property (
    (take && VARIANT == DUAL_SELECT && !input_choice[1])
      |=> mem_bus.wr_data[1] == $past(data_in_first[1]))
    else $error("select low did not take first input");

  choice_high_a: assert property (
    (take && VARIANT == DUAL_SELECT && input_choice[0])
      |=> mem_bus.wr_data[0] == $past(data_in_second[0]))
    else $error("select high did not take second input");

  // The store is not cleared, so early positions read as unknown; the
  // case equality keeps such a position from looking like a mismatch.
  out_last_a: assert property (
    (state_ff == ST_MOVE) |=> data_out === $past(mem_bus.rd_data))
    else $error("output does not show last stage");

  phase_shift_a: assert property (
    (ph2_start && shift_ready) |=> (state_ff == ST_MOVE && half_ff) ##1 state_ff == ST_IDLE)
    else $error("phase two pulse did not shift second half");

  ptr_step_a: assert property (
    (state_ff == ST_MOVE && !half_ff) |=> ptr_ff[0] == PW'($past(ptr_ff[0]) + 1'b1))
    else $error("half pointer did not advance by one");

  master_slave_a: assert property (
    mem_bus.wr_en |-> $past(take) && !take)
    else $error("slave write without master capture");

  buf_full_a: assert property (
    (buf_cnt_ff == 2'(BUF_DEPTH)) |-> !shift_ready && !take && !push)
    else $error("shift taken with buffer full");

  recirc_c: cover property (take && load_control ##1 state_ff == ST_MOVE);
  stall_c: cover property (buf_cnt_ff == 2'(BUF_DEPTH) ##1 pop);
  both_phases_c: cover property (ph1_start && take ##[2:8] ph2_start && take);

endmodule

// ==== core/dsr_pkg.sv ====
// Shared constants and types for the two-phase dynamic shift register.
// Assumes a single core clock of 20 MHz; all times are turned into cycles here.
package dsr_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int TOTAL_BITS = 2048;
  localparam int DUAL_LEN = 1024;
  localparam int NUM_LANES = 2;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASE_START_MIN_NS = 165;
  localparam int PHASE_START_MIN_CYC = (PHASE_START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_GAP_MIN_NS = 10;
  localparam int PHASE_GAP_RAW_CYC = (PHASE_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_GAP_MIN_CYC = (PHASE_GAP_RAW_CYC < 1) ? 1 : PHASE_GAP_RAW_CYC;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] LANE_RESET = 2'h0;
  localparam logic [1:0] COUNT_RESET = 2'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum int {
    DUAL_RECIRC = 0,
    DUAL_SELECT = 1,
    SINGLE_RECIRC = 2
  } variant_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_MOVE = 2'h1
  } shift_state_t;

endpackage

// ==== core/dsr_store_if.sv ====
// Port bundle between the shift control and its bit store.
// Assumes the store answers a read one clock after the request.
`timescale 1ns/1ps
interface dsr_store_if #(
  parameter int AW = 10,
  parameter int DW = 2
);
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;

  modport ctrl (
    output rd_en,
    output rd_addr,
    input rd_data,
    output wr_en,
    output wr_addr,
    output wr_data
  );

  modport store (
    input rd_en,
    input rd_addr,
    output rd_data,
    input wr_en,
    input wr_addr,
    input wr_data
  );
endinterface

// ==== core/dsr_store.sv ====
// Bit store for the shift register cells, one word per position of each lane.
// Assumes the controller never reads and writes the same word in one cycle.
`timescale 1ns/1ps
module dsr_store #(
  parameter int DEPTH = 1024,
  parameter int DW = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  dsr_store_if.store port_s
);
  import dsr_pkg::*;

  logic [DW-1:0] cell_mem [DEPTH];
  logic [DW-1:0] rd_data_ff;

  // ----------------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------------
  // The array has no reset: like the charge it models, its content is
  // undefined until the first full pass of data.
  always_ff @(posedge core_clk) begin
    if (port_s.wr_en) begin
      cell_mem[port_s.wr_addr] <= port_s.wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data_ff <= '0;
    end else if (port_s.rd_en) begin
      rd_data_ff <= cell_mem[port_s.rd_addr];
    end
  end

  assign port_s.rd_data = rd_data_ff;

endmodule

// ==== bench/upstream_clock_gen.sv ====
// Upstream two-phase clock generator model for the shift register bench.
// Assumes phase levels are sampled on core_clk and that shift_ready is honoured.
`timescale 1ns/1ps
module upstream_clock_gen (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic slow,
  input wire logic shift_ready,
  output logic phase_1,
  output logic phase_2
);
  // ----------------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------------
  // Phases alternate and never overlap; a start waits for shift_ready, since
  // a pulse that meets a refusal would silently lose its entered bit.
  logic sel_ff;
  int gap_ff;

  initial begin
    phase_1 = 1'b0;
    phase_2 = 1'b0;
    sel_ff = 1'b0;
    gap_ff = 0;
  end

  always begin
    @(posedge core_clk);
    if (!reset && run && shift_ready) begin
      if (sel_ff) begin
        phase_2 <= 1'b1;
      end else begin
        phase_1 <= 1'b1;
      end
      repeat (2) @(posedge core_clk);
      phase_1 <= 1'b0;
      phase_2 <= 1'b0;
      // At least two idle cycles keep the gap well above 10 ns and the
      // start-to-start spacing above 165 ns, far below 100 us.
      repeat (2 + (slow ? gap_ff % 4 : 0)) @(posedge core_clk);
      gap_ff = gap_ff + 1;
      sel_ff = !sel_ff;
    end
  end
endmodule

// ==== bench/dual_phase_dynamic_shift_register_tb.sv ====
// Self-checking bench running all three variants side by side on one stimulus.
// Assumes a 20 MHz core clock and the upstream clock generator model.
`timescale 1ns/1ps
module dual_phase_dynamic_shift_register_tb;
  import dsr_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic core_clk = 1'b0, reset = 1'b1, load_control = 1'b0, out_ready = 1'b0;
  logic run = 1'b0, slow = 1'b0, stall = 1'b0, p1_prev = 1'b0, p2_prev = 1'b0;
  logic phase_1, phase_2, ready_all;
  logic [1:0] input_choice = 2'h0, data_in_first = 2'h0, data_in_second = 2'h0;
  logic [1:0] dout [3];
  logic [1:0] odata [3];
  logic srdy [3];
  logic oval [3];
  logic [1:0] dout_exp [3];
  logic lane_q [3][2][$];
  logic [1:0] exp_q [3][$];
  int err_total = 0, tests_run = 0, shifts = 0, seed = 71;

  always #25 core_clk = ~core_clk;
  assign ready_all = srdy[0] & srdy[1] & srdy[2];

  for (genvar v = 0; v < 3; v++) begin : g_var
    dual_phase_dynamic_shift_register #(
      .VARIANT(variant_t'(v))
    ) i_dual_phase_dynamic_shift_register (
      .core_clk(core_clk), .reset(reset), .phase_1(phase_1), .phase_2(phase_2),
      .load_control(load_control), .input_choice(input_choice),
      .data_in_first(data_in_first), .data_in_second(data_in_second),
      .data_out(dout[v]), .shift_ready(srdy[v]), .out_valid(oval[v]),
      .out_ready(out_ready), .out_data(odata[v]));
  end

  upstream_clock_gen i_upstream_clock_gen (.core_clk(core_clk), .reset(reset), .run(run),
    .slow(slow), .shift_ready(ready_all), .phase_1(phase_1), .phase_2(phase_2));

  task automatic check(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Stimulus and reference model
  // ----------------------------------------------------------------------
  // Load control stays low until every lane is filled, so no unknown bit
  // is ever recirculated.
  always @(posedge core_clk) begin
    logic [31:0] r;
    r = $random(seed);
    if (!reset) begin
      data_in_first <= r[1:0];
      data_in_second <= r[3:2];
      input_choice <= r[5:4];
      load_control <= (shifts >= TOTAL_BITS) && r[6];
      out_ready <= !stall && (r[8:7] != 2'h0);
    end
  end

  always @(posedge core_clk) begin
    logic o, e;
    logic [1:0] w;
    p1_prev <= reset ? 1'b0 : phase_1;
    p2_prev <= reset ? 1'b0 : phase_2;
    if (!reset && ready_all && ((phase_1 && !p1_prev) || (phase_2 && !p2_prev))) begin
      for (int v = 0; v < 3; v++) begin
        if (^dout_exp[v] !== 1'bx) check(dout[v], dout_exp[v]);
        w = 2'h0;
        for (int r = 0; r < (v == 2 ? 1 : 2); r++) begin
          o = (lane_q[v][r].size() == (v == 2 ? TOTAL_BITS : DUAL_LEN)) ?
              lane_q[v][r].pop_front() : 1'bx;
          if (v == 1) e = input_choice[r] ? data_in_second[r] : data_in_first[r];
          else e = load_control ? o : data_in_first[r];
          lane_q[v][r].push_back(e);
          w[r] = o;
        end
        exp_q[v].push_back(w);
        dout_exp[v] = w;
      end
      shifts++;
    end
  end

  // ----------------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    logic [1:0] w;
    for (int v = 0; v < 3; v++) begin
      if (!reset && oval[v] === 1'b1 && out_ready) begin
        if (exp_q[v].size() == 0) begin
          err_total++;
          $display("CHECK FAILED t=%0t got=%h exp=%h", $time, odata[v], 2'h0);
        end else begin
          w = exp_q[v].pop_front();
          if (^w !== 1'bx) check(odata[v], w);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    for (int v = 0; v < 3; v++) begin
      check(dout[v], 2'h0);
      check({oval[v], srdy[v]}, 2'h1);
    end
    run <= 1'b1;
    while (shifts < 2100) @(posedge core_clk);
    // A stalled receiver fills the buffer; the model must wait, not lose words.
    stall <= 1'b1;
    repeat (60) @(posedge core_clk);
    #1;
    for (int v = 0; v < 3; v++) check({oval[v], srdy[v]}, 2'h2);
    stall <= 1'b0;
    slow <= 1'b1;
    // The single lane needs a full 2048 shifts before a recirculated bit
    // comes back out, so the run goes 304 shifts past twice that length.
    while (shifts < 4400) @(posedge core_clk);
    run <= 1'b0;
    repeat (60) @(posedge core_clk);
    #1;
    for (int v = 0; v < 3; v++) check({oval[v], exp_q[v].size() != 0}, 2'h0);
    end_sim;
  end

  initial begin
    #(50000 * 50);
    err_total++;
    end_sim;
  end
endmodule
